// file: core/swm_master.sv
// Single-wire bus master: reset and presence, command byte, identity read and one search pass.
// Assumes an open-drain line with an external pull-up; i_dq comes straight from the pin.
//
// Functional notes
// - All fields travel least significant bit first.
// - Every slot begins with master pulling low.
// - Line left released whenever master is idle.
// - Reset, presence, command, then data phase.
// - Reset pulse holds line low 480 us.
// - Command is exactly eight bits.
// - Identity read only with one slave attached.
// - Search: read bit, complement, write choice.
// - Slot 60-120 us; one short, zero long.
// - Read bit sampled within 15 us.
// - Released line 480 us after reset pulse.
// - CRC x^8+x^5+x^4+1 over first 56 bits.
`timescale 1ns/1ps
`default_nettype none
`include "swm_defs.svh"

module swm_master
   import swm_pkg::*;
#(
   parameter int CYC_PER_US = `SWM_CLK_MHZ,
   parameter int RESET_LOW_CYC = `SWM_RESET_LOW_US * CYC_PER_US,
   parameter int RESET_HIGH_CYC = `SWM_RESET_HIGH_US * CYC_PER_US
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_start,
   input wire op_e i_op,
   input wire logic [63:0] i_search_path,
   output logic o_busy,
   output logic o_done,
   output logic o_presence,
   output logic o_no_device,
   output logic o_crc_ok,
   output logic [63:0] o_rom,
   output logic [63:0] o_conflict,
   input wire logic i_dq,
   output logic o_dq_out,
   output logic o_dq_oe_b
);

   localparam logic [`SWM_CNT_W-1:0] RST_LOW_END = `SWM_CNT_W'(RESET_LOW_CYC - 1);
   localparam logic [`SWM_CNT_W-1:0] RST_HIGH_END = `SWM_CNT_W'(RESET_HIGH_CYC - 1);
   localparam logic [`SWM_CNT_W-1:0] PRES_AT = `SWM_CNT_W'(`SWM_PRES_SAMPLE_US * CYC_PER_US - 1);

   // ----------------------------------------------------------------------------
   // Pin synchroniser and slot engine
   // ----------------------------------------------------------------------------
   logic sync1_q, sync2_q, slot_pull;
   slot_if sl ();

   // Two flops before the line is used; the first is read only by the second.
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end else begin
         sync1_q <= i_dq;
         sync2_q <= sync1_q;
      end
   end

   slot_engine #(.CYC_PER_US(CYC_PER_US)) u_slot (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_line(sync2_q),
      .o_pull(slot_pull),
      .sl(sl)
   );

   // ----------------------------------------------------------------------------
   // Transaction controller
   // ----------------------------------------------------------------------------
   state_e state_q, state_d;
   op_e op_q, op_d;
   logic [`SWM_CNT_W-1:0] cnt_q, cnt_d;
   logic [5:0] idx_q, idx_d;
   logic [63:0] rom_q, rom_d, conf_q, conf_d;
   logic [7:0] crc_q, crc_d, cmd_byte;
   logic pend_q, pend_d, a_q, a_d, choice_q, choice_d, pres_q, pres_d;
   logic nodev_q, nodev_d, crcok_q, crcok_d, done_q, done_d, rpull_q, rpull_d;

   // One CRC step in the reflected form used on the bus.
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
      logic fb;
      fb = c[0] ^ b;
      crc_step = (c >> 1) ^ (fb ? `SWM_CRC_POLY : 8'h00);
   endfunction : crc_step

   assign cmd_byte = (op_q == OP_SEARCH) ? `SWM_CMD_SEARCH : `SWM_CMD_READ_ID;
   assign sl.start = !pend_q && (state_q inside {ST_CMD, ST_READ, ST_SRCH_A, ST_SRCH_B, ST_SRCH_W});
   assign sl.wr = (state_q == ST_CMD) || (state_q == ST_SRCH_W);
   assign sl.wbit = (state_q == ST_CMD) ? cmd_byte[idx_q[2:0]] : choice_q;

   // Next values of the controller.
   always_comb begin
      state_d = state_q;
      op_d = op_q;
      cnt_d = cnt_q;
      idx_d = idx_q;
      rom_d = rom_q;
      conf_d = conf_q;
      crc_d = crc_q;
      pend_d = pend_q;
      a_d = a_q;
      choice_d = choice_q;
      pres_d = pres_q;
      nodev_d = nodev_q;
      crcok_d = crcok_q;
      done_d = 1'b0;
      pend_d = (pend_q || sl.start) && !sl.done;
      case (state_q)
         ST_IDLE: begin
            if (i_start) begin
               state_d = ST_RST_LOW;
               op_d = i_op;
               cnt_d = '0;
               idx_d = '0;
               conf_d = '0;
               crc_d = '0;
               pres_d = 1'b0;
               nodev_d = 1'b0;
               crcok_d = 1'b0;
            end
         end
         ST_RST_LOW: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == RST_LOW_END) begin
               state_d = ST_RST_WAIT;
               cnt_d = '0;
            end
         end
         ST_RST_WAIT: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == PRES_AT) begin
               pres_d = !sync2_q;
               state_d = ST_RST_REC;
            end
         end
         ST_RST_REC: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == RST_HIGH_END) begin
               if (!pres_q || op_q == OP_RESET) begin
                  state_d = ST_IDLE;
                  done_d = 1'b1;
               end else begin
                  state_d = ST_CMD;
               end
            end
         end
         ST_CMD: begin
            if (sl.done) begin
               idx_d = idx_q + 1'b1;
               if (idx_q[2:0] == `SWM_CMD_LAST_BIT) begin
                  idx_d = '0;
                  state_d = (op_q == OP_SEARCH) ? ST_SRCH_A : ST_READ;
               end
            end
         end
         ST_SRCH_A: begin
            if (sl.done) begin
               a_d = sl.rbit;
               state_d = ST_SRCH_B;
            end
         end
         ST_SRCH_B: begin
            if (sl.done) begin
               if (a_q && sl.rbit) begin
                  nodev_d = 1'b1;
                  state_d = ST_IDLE;
                  done_d = 1'b1;
               end else begin
                  choice_d = (a_q != sl.rbit) ? a_q : i_search_path[idx_q];
                  conf_d[idx_q] = (a_q == sl.rbit);
                  state_d = ST_SRCH_W;
               end
            end
         end
         ST_READ, ST_SRCH_W: begin
            if (sl.done) begin
               rom_d[idx_q] = (state_q == ST_READ) ? sl.rbit : choice_q;
               if (7'(idx_q) < `SWM_CRC_DATA_BITS) begin
                  crc_d = crc_step(crc_q, rom_d[idx_q]);
               end
               idx_d = idx_q + 1'b1;
               state_d = (state_q == ST_READ) ? ST_READ : ST_SRCH_A;
               if (idx_q == `SWM_ID_LAST_BIT) begin
                  crcok_d = (crc_q == rom_d[63:56]);
                  state_d = ST_IDLE;
                  done_d = 1'b1;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      rpull_d = (state_d == ST_RST_LOW);
   end

   // Controller registers.
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_q <= ST_IDLE;
         op_q <= OP_RESET;
         cnt_q <= '0;
         idx_q <= '0;
         rom_q <= '0;
         conf_q <= '0;
         crc_q <= '0;
         pend_q <= 1'b0;
         a_q <= 1'b0;
         choice_q <= 1'b0;
         pres_q <= 1'b0;
         nodev_q <= 1'b0;
         crcok_q <= 1'b0;
         done_q <= 1'b0;
         rpull_q <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         cnt_q <= cnt_d;
         idx_q <= idx_d;
         rom_q <= rom_d;
         conf_q <= conf_d;
         crc_q <= crc_d;
         pend_q <= pend_d;
         a_q <= a_d;
         choice_q <= choice_d;
         pres_q <= pres_d;
         nodev_q <= nodev_d;
         crcok_q <= crcok_d;
         done_q <= done_d;
         rpull_q <= rpull_d;
      end
   end

   // Outputs; the pin is only ever pulled low, the pull-up makes the high level.
   assign o_dq_out = 1'b0;
   assign o_dq_oe_b = !(rpull_q || slot_pull);
   assign o_busy = (state_q != ST_IDLE);
   assign o_done = done_q;
   assign o_presence = pres_q;
   assign o_no_device = nodev_q;
   assign o_crc_ok = crcok_q;
   assign o_rom = rom_q;
   assign o_conflict = conf_q;

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   sequence s_reset_end;
      state_q == ST_RST_LOW ##1 state_q == ST_RST_WAIT;
   endsequence
   a_reset_low_len: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      state_q == ST_RST_LOW && state_d != ST_RST_LOW |-> cnt_q == RST_LOW_END && !o_dq_oe_b)
      else $error("reset pulse has the wrong length");
   a_reset_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      s_reset_end |-> o_dq_oe_b)
      else $error("line not released after reset pulse");
   a_idle_released: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      state_q == ST_IDLE && $past(state_q) == ST_IDLE |-> o_dq_oe_b)
      else $error("line pulled while idle");
   a_cmd_after_reset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      $rose(state_q == ST_CMD) |-> $past(state_q) == ST_RST_REC && $past(cnt_q) == RST_HIGH_END && pres_q)
      else $error("command sent without reset and presence");
   a_cmd_lsb_first: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      sl.start && state_q == ST_CMD |-> sl.wr && sl.wbit == cmd_byte[idx_q[2:0]])
      else $error("command bit out of order");
   a_cmd_eight_bits: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      state_q == ST_CMD && state_d != ST_CMD |-> sl.done && idx_q[2:0] == `SWM_CMD_LAST_BIT)
      else $error("command phase left before eight bits");
   a_search_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      state_q == ST_SRCH_B && sl.done && !(a_q && sl.rbit) |=> state_q == ST_SRCH_W && (choice_q == a_q || conf_q[idx_q]))
      else $error("search write does not follow the read pair");
   a_crc_result: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      done_q && $past(idx_q) == `SWM_ID_LAST_BIT && !nodev_q |-> o_crc_ok == ($past(crc_q) == o_rom[63:56]))
      else $error("crc verdict inconsistent");
endmodule : swm_master

`default_nettype wire

// file: core/swm_defs.svh
// Timing, command and field constants for the single-wire bus master.
// Assumes a 50 MHz system clock; every cycle count is derived from a time in microseconds.
`ifndef SWM_DEFS_SVH
`define SWM_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock and conversion
// ----------------------------------------------------------------------------
`define SWM_CLK_MHZ 50
`define SWM_CYC(us) ((us) * `SWM_CLK_MHZ)

// ----------------------------------------------------------------------------
// Bus times in microseconds
// ----------------------------------------------------------------------------
`define SWM_RESET_LOW_US 480
`define SWM_RESET_HIGH_US 480
`define SWM_PRES_SAMPLE_US 70
`define SWM_SLOT_US 70
`define SWM_REC_US 5
`define SWM_WR1_LOW_US 6
`define SWM_WR0_LOW_US 65
`define SWM_RD_LOW_US 2
`define SWM_RD_SAMPLE_US 12
`define SWM_RDV_US 15

// ----------------------------------------------------------------------------
// Commands and field sizes
// ----------------------------------------------------------------------------
`define SWM_CMD_READ_ID 8'h33
`define SWM_CMD_SEARCH 8'hf0
`define SWM_CMD_LAST_BIT 3'h7
`define SWM_ID_LAST_BIT 6'h3f
`define SWM_CRC_DATA_BITS 7'h38
`define SWM_CRC_POLY 8'h8c
`define SWM_CNT_W 16

`endif

// file: core/swm_pkg.sv
// Types shared by the single-wire bus master and its slot engine.
// Assumes nothing beyond a SystemVerilog compiler.
package swm_pkg;

   // ----------------------------------------------------------------------------
   // User operations and controller states
   // ----------------------------------------------------------------------------
   typedef enum logic [1:0] {OP_RESET, OP_READ_ID, OP_SEARCH} op_e;

   typedef enum logic [3:0] {
      ST_IDLE, ST_RST_LOW, ST_RST_WAIT, ST_RST_REC, ST_CMD, ST_READ, ST_SRCH_A, ST_SRCH_B, ST_SRCH_W
   } state_e;

endpackage : swm_pkg

// file: core/slot_if.sv
// Handshake between the transaction controller and the bit-slot engine.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none

interface slot_if;
   logic start;
   logic wr;
   logic wbit;
   logic done;
   logic rbit;
   modport ctrl (output start, output wr, output wbit, input done, input rbit);
   modport engine (input start, input wr, input wbit, output done, output rbit);
endinterface : slot_if

`default_nettype wire

// file: core/slot_engine.sv
// Bit-slot engine: generates one write or read slot per start request.
// Assumes i_line is already synchronised to i_sys_clk and that start comes only while idle.
`timescale 1ns/1ps
`default_nettype none
`include "swm_defs.svh"

module slot_engine
   import swm_pkg::*;
#(
   // Cycles per microsecond; a bench may lower it to shorten every slot in proportion.
   parameter int CYC_PER_US = `SWM_CLK_MHZ
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_line,
   output logic o_pull,
   slot_if.engine sl
);

   localparam logic [`SWM_CNT_W-1:0] SLOT_END = `SWM_CNT_W'((`SWM_SLOT_US + `SWM_REC_US) * CYC_PER_US - 1);
   localparam logic [`SWM_CNT_W-1:0] SAMPLE_AT = `SWM_CNT_W'(`SWM_RD_SAMPLE_US * CYC_PER_US);
   localparam logic [`SWM_CNT_W-1:0] RDV_CYC = `SWM_CNT_W'(`SWM_RDV_US * CYC_PER_US);

   logic busy_q, busy_d, wr_q, wr_d, wbit_q, wbit_d, rbit_q, rbit_d, pull_q, pull_d;
   logic [`SWM_CNT_W-1:0] cnt_q, cnt_d;

   // Low time of the slot: a one is a short pulse, a zero holds most of the slot.
   function automatic logic [`SWM_CNT_W-1:0] low_len(input logic wr, input logic b);
      if (!wr) begin
         low_len = `SWM_CNT_W'(`SWM_RD_LOW_US * CYC_PER_US);
      end else if (b) begin
         low_len = `SWM_CNT_W'(`SWM_WR1_LOW_US * CYC_PER_US);
      end else begin
         low_len = `SWM_CNT_W'(`SWM_WR0_LOW_US * CYC_PER_US);
      end
   endfunction : low_len

   assign sl.done = busy_q && (cnt_q == SLOT_END);
   assign sl.rbit = rbit_q;
   assign o_pull = pull_q;

   // Next-state logic; the pull is registered from the next count so the pin never glitches.
   always_comb begin
      busy_d = busy_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      wbit_d = wbit_q;
      rbit_d = rbit_q;
      if (!busy_q) begin
         if (sl.start) begin
            busy_d = 1'b1;
            cnt_d = '0;
            wr_d = sl.wr;
            wbit_d = sl.wbit;
         end
      end else begin
         cnt_d = cnt_q + 1'b1;
         if (!wr_q && cnt_q == SAMPLE_AT) begin
            rbit_d = i_line;
         end
         if (cnt_q == SLOT_END) begin
            busy_d = 1'b0;
         end
      end
      pull_d = busy_d && (cnt_d < low_len(wr_d, wbit_d));
   end

   // State registers.
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         busy_q <= 1'b0;
         cnt_q <= '0;
         wr_q <= 1'b0;
         wbit_q <= 1'b0;
         rbit_q <= 1'b1;
         pull_q <= 1'b0;
      end else begin
         busy_q <= busy_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         wbit_q <= wbit_d;
         rbit_q <= rbit_d;
         pull_q <= pull_d;
      end
   end

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   a_pull_within_low: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      $fell(pull_q) |-> busy_q && cnt_q == low_len(wr_q, wbit_q))
      else $error("slot low time has the wrong length");

   a_slot_starts_low: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      !busy_q && sl.start |=> pull_q && cnt_q == '0)
      else $error("slot did not open with a falling edge");

   a_read_sample_window: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      busy_q && !wr_q && $changed(rbit_q) |-> $past(cnt_q) == SAMPLE_AT && SAMPLE_AT < RDV_CYC)
      else $error("read bit taken outside the valid window");

endmodule : slot_engine

`default_nettype wire

// file: sim/id_slave_model.sv
// Behavioural model of the identity slave that sits at the far end of the single-wire line.
// Assumes the bench resolves the wired-AND line with a pull-up and feeds the result to i_line.
`timescale 1ns/1ps
`default_nettype none

module id_slave_model (
   input wire logic i_line,
   output logic o_oe_b
);
   // ---------------------------------------------------------------
   // Settings the bench changes between transactions
   // ---------------------------------------------------------------
   logic [63:0] id = 64'h0;
   bit present = 1'b1;
   int pres_wait_ns = 1200;
   int pres_low_ns = 4800;
   bit mute = 1'b0;
   logic [7:0] last_cmd = 8'h00;
   // Times run 25 times faster than nominal, matching the bench's two cycles per microsecond.
   localparam int SAMPLE_NS = 1200;
   localparam int HOLD_NS = 600;
   localparam int RESET_MIN_NS = 4800;
   time fall_t = 0;
   bit ext_fall = 1'b0;
   event reset_seen;

   // Write slot: the falling edge starts the delay, then the line is sampled.
   task automatic get_bit(output logic b);
      @(negedge i_line);
      #(SAMPLE_NS);
      b = i_line;
      wait (i_line === 1'b1);
   endtask : get_bit

   // Read slot: a zero is held low past the master's sample point, a one is never driven.
   task automatic put_bit(input logic b);
      @(negedge i_line);
      if (!b) begin
         o_oe_b = 1'b0;
         #(HOLD_NS);
         o_oe_b = 1'b1;
      end
   endtask : put_bit

   // ---------------------------------------------------------------
   // Transaction sequence
   // ---------------------------------------------------------------
   // Only a long low from the master counts as reset, wherever the model stands;
   // a short write-zero never restarts it, and its own presence pull is ignored.
   always @(negedge i_line) begin
      fall_t = $time;
      ext_fall = (o_oe_b === 1'b1);
   end

   always @(posedge i_line) begin
      if (ext_fall && ($time - fall_t) >= RESET_MIN_NS) -> reset_seen;
   end

   // One transaction: presence, command, then the data phase of that command.
   task automatic run_txn();
      logic [7:0] cmd;
      logic b;
      if (!present) return;
      #(pres_wait_ns);
      o_oe_b = 1'b0;
      #(pres_low_ns);
      o_oe_b = 1'b1;
      if (mute) return;
      for (int i = 0; i < 8; i++) begin
         get_bit(b);
         cmd[i] = b;
      end
      last_cmd = cmd;
      if (cmd == 8'h33 || cmd == 8'h0f) begin
         for (int i = 0; i < 64; i++) put_bit(id[i]);
      end else if (cmd == 8'hf0) begin
         for (int i = 0; i < 64; i++) begin
            put_bit(id[i]);
            put_bit(!id[i]);
            get_bit(b);
            if (b !== id[i]) break;
         end
      end // Any other code leaves the line alone until the next reset.
   endtask : run_txn

   // The transaction runs as a child so that a reset in mid-transaction cuts it short.
   initial begin : life
      o_oe_b = 1'b1;
      @(reset_seen);
      forever begin
         fork
            run_txn();
         join_none
         @(reset_seen);
         disable fork;
         o_oe_b = 1'b1;
      end
   end
endmodule : id_slave_model

`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the single-wire bus master against one identity slave model.
// Assumes the design files and package are compiled first; bus timing runs 25 times faster than nominal.
`timescale 1ns/1ps
`default_nettype none

module tb;
   import swm_pkg::*;
   // Bus timing runs 25 times faster than nominal so that a full search fits the run.
   localparam int CYC_US = 2;
   localparam int RST_LOW = 480 * CYC_US;
   localparam int RST_HIGH = 480 * CYC_US;
   localparam int WR1 = 6 * CYC_US, WR0 = 65 * CYC_US, RDL = 2 * CYC_US;
   localparam int LIMIT = 90000;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic start = 1'b0;
   op_e op = OP_RESET;
   logic [63:0] search_path = 64'h0;
   logic busy, done, presence, no_device, crc_ok, dq_out, dq_oe_b, mdl_oe_b;
   logic [63:0] rom, conflict;
   wire logic line;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;
   int low_run = 0;
   int hi_run = 0;
   int last_low = 0;

   // ---------------------------------------------------------------
   // Clock, line and instances
   // ---------------------------------------------------------------
   always #10 sys_clk = ~sys_clk;
   // Open drain with pull-up: low if either party pulls.
   assign line = (dq_oe_b === 1'b0 || mdl_oe_b === 1'b0) ? 1'b0 : 1'b1;

   swm_master #(.CYC_PER_US(CYC_US), .RESET_LOW_CYC(RST_LOW), .RESET_HIGH_CYC(RST_HIGH)) dut (
      .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_start(start), .i_op(op), .i_search_path(search_path),
      .o_busy(busy), .o_done(done), .o_presence(presence), .o_no_device(no_device), .o_crc_ok(crc_ok),
      .o_rom(rom), .o_conflict(conflict), .i_dq(line), .o_dq_out(dq_out), .o_dq_oe_b(dq_oe_b));
   // A single slave, so the identity read never collides.
   id_slave_model slave (.i_line(line), .o_oe_b(mdl_oe_b));

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s saw %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up

   // Pulse widths are watched on every pull the master makes; released time on the first pull after a reset pulse.
   always @(posedge sys_clk) begin
      cycles++;
      if (dq_oe_b === 1'b0) begin
         if (low_run == 0 && last_low == RST_LOW) chk(hi_run >= RST_HIGH, 1'b1, "released time");
         low_run++;
         hi_run = 0;
      end else begin
         if (low_run != 0) chk(low_run inside {RST_LOW, WR1, WR0, RDL}, 1'b1, "low width");
         if (low_run != 0) last_low = low_run;
         low_run = 0;
         hi_run++;
      end
      if (cycles == LIMIT) begin
         n_fail++;
         $display("unexpected at %0t: run did not finish", $time);
         wrap_up();
      end
   end

   // Reflected CRC, zero start, appended above the 56 data bits.
   function automatic logic [63:0] make_id(input logic [55:0] body);
      logic [7:0] crc;
      crc = 8'h00;
      for (int i = 0; i < 56; i++) begin
         if (crc[0] ^ body[i]) crc = (crc >> 1) ^ 8'h8c;
         else crc = crc >> 1;
      end
      return {crc, body};
   endfunction : make_id

   // ---------------------------------------------------------------
   // Operation helpers
   // ---------------------------------------------------------------
   task automatic launch(input op_e o);
      @(negedge sys_clk);
      op = o;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      chk(busy, 1'b1, "busy after start");
   endtask : launch

   task automatic finish_op();
      int n;
      n = 0;
      while (done !== 1'b1 && n < 40000) begin
         @(negedge sys_clk);
         n++;
      end
      chk(done, 1'b1, "done");
      chk(busy, 1'b0, "busy in done cycle");
      chk(dq_oe_b, 1'b1, "line left released");
      chk(dq_out, 1'b0, "pin never driven high");
   endtask : finish_op

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      slave.present = 1'b1;
      slave.pres_wait_ns = 600;
      slave.pres_low_ns = 2400;
      launch(OP_RESET);
      finish_op();
      chk(presence, 1'b1, "prompt presence");
      chk(last_low, RST_LOW, "reset low width");
      slave.present = 1'b0;
      launch(OP_RESET);
      finish_op();
      chk(presence, 1'b0, "no presence");
      $display("test reset_presence done");
   endtask : t_reset

   // A second start while busy must be ignored, so the command stays identity-read.
   task automatic t_read_id();
      logic [63:0] id;
      id = make_id({48'h3c71e2a90d46, 8'h5a}); // Family value is arbitrary.
      slave.id = id;
      slave.present = 1'b1;
      slave.pres_wait_ns = 2200;
      slave.pres_low_ns = 9200;
      launch(OP_READ_ID);
      repeat (1000) @(negedge sys_clk);
      op = OP_SEARCH;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      finish_op();
      chk(presence, 1'b1, "slow presence");
      chk(slave.last_cmd, 8'h33, "command on wire");
      chk(rom, id, "identity");
      chk(crc_ok, 1'b1, "good crc");
      chk(conflict, 64'h0, "no conflicts");
      $display("test read_id done");
   endtask : t_read_id

   task automatic t_search();
      logic [63:0] id;
      id = make_id({48'h80f5a13c7e02, 8'ha7}) ^ {8'h81, 56'h0};
      slave.id = id;
      launch(OP_SEARCH);
      finish_op();
      chk(slave.last_cmd, 8'hf0, "command on wire");
      chk(rom, id, "search identity");
      chk(conflict, 64'h0, "single slave conflicts");
      chk(no_device, 1'b0, "slave answered");
      chk(crc_ok, 1'b0, "bad crc");
      $display("test search done");
   endtask : t_search

   task automatic t_absent();
      slave.present = 1'b0;
      launch(OP_SEARCH);
      finish_op();
      chk(presence, 1'b0, "absent slave");
      chk(no_device, 1'b0, "no search without presence");
      // A slave that answers presence but ignores the command reads back as 1,1.
      slave.present = 1'b1;
      slave.mute = 1'b1;
      launch(OP_SEARCH);
      finish_op();
      chk(presence, 1'b1, "silent slave present");
      chk(no_device, 1'b1, "no slave answered search");
      $display("test absent done");
   endtask : t_absent

   initial begin
      repeat (10) @(negedge sys_clk);
      rst_b = 1'b1;
      chk(dq_oe_b, 1'b1, "released after reset");
      chk(busy, 1'b0, "idle after reset");
      t_reset();
      t_read_id();
      t_search();
      t_absent();
      wrap_up();
   end
endmodule : tb

`default_nettype wire
